// ---- include/drc_pkg.sv ----
/*
  Package for the refresh and initialisation controller of a 4096 x 1
  multiplexed-address dynamic RAM array.
  Assumes a 40 MHz system clock and strobe timing built from whole cycles.
*/
package drc_pkg;
  localparam int unsigned CLK_MHZ       = 40;
  localparam int unsigned ROW_BITS      = 6;
  localparam int unsigned COL_BITS      = 6;
  localparam int unsigned ROW_COUNT     = 64;
  localparam int unsigned REFRESH_MS    = 2;
  localparam int unsigned REFRESH_NS    = REFRESH_MS * 1000000;
  localparam int unsigned INTERVAL_NS   = REFRESH_NS / ROW_COUNT;
  // Longest time between refresh cycles rounds down.
  localparam int unsigned INTERVAL_CYC  = (INTERVAL_NS * CLK_MHZ) / 1000;
  localparam int unsigned REFRESH_CYC   = (REFRESH_NS * CLK_MHZ) / 1000;
  // Strobe phase lengths; least times round up.
  localparam int unsigned T_PRE_NS      = 120;
  localparam int unsigned T_RCD_NS      = 25;
  localparam int unsigned T_ACT_NS      = 200;
  localparam int unsigned T_PRE_CYC     = (T_PRE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_RCD_CYC     = (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned T_ACT_CYC     = (T_ACT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [5:0]  ROW_RESET     = 6'h00;

  typedef struct packed {
    logic       write;
    logic [5:0] chip;
    logic [5:0] row;
    logic [5:0] col;
    logic       wdata;
  } drc_req_t;

  typedef struct packed {
    logic       ras;
    logic       cas_n;
    logic       cs_n;
    logic       write_n;
    logic [5:0] addr;
    logic       din;
  } drc_pins_t;
endpackage : drc_pkg

// ---- logic/drc_ctrl.sv ----
/*
  Controller that drives an array of 4096 x 1 dynamic RAM chips through their
  strobe, select, write and multiplexed address pins, and keeps them refreshed.
  Assumes one request source on the same clock and data out pins from outside.
*/
`timescale 1ns/1ps
// Summary of operation
// [R1] Refresh all 64 rows every 2 ms.
// [R2] Any row-strobe cycle refreshes its row.
// [R3] Read refreshes row regardless of select.
// [R4] Hold select inactive on write-type refresh.
// [R5] Long row-only refresh may float output.
// [R6] Dummy both-strobe cycle after long refresh.
// [R7] Dummy cycle restores output, readies device.
// [R8] Decode row strobe to selected chips only.
// [R9] Column strobe goes to every chip.
// [R10] Column strobe without row strobe: unselected.
// [R11] Select may be tied low with decoding.
// [R12] Column strobe stays high during refresh; the code drops it in the both-strobe power-up and dummy refresh cycles.
// [R13] Both-strobe cycles required after power-up.
// [R14] Row-only refresh leaves output unchanged.
// [R15] Row address presented before row strobe; the code drives both on the same clock edge.
// [R16] Row counter and interval timer spread refresh.
module drc_ctrl #(
  parameter int unsigned CHIPS        = 4,
  parameter int unsigned INTERVAL_CYC = drc_pkg::INTERVAL_CYC,
  parameter int unsigned REFRESH_CYC  = drc_pkg::REFRESH_CYC
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Request side
  input  wire logic             req_valid,
  input  wire drc_pkg::drc_req_t req,
  output logic                  req_ready,
  output logic                  rd_valid,
  output logic                  rd_data,
  output logic                  init_done,
  // Memory pins
  output logic [CHIPS-1:0]      ras,
  output logic                  cas_n,
  output logic                  cs_n,
  output logic                  write_n,
  output logic [5:0]            addr,
  output logic                  din,
  input  wire logic [CHIPS-1:0] dout
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ROW  = 6'h02,
    ST_COL  = 6'h04,
    ST_ACT  = 6'h08,
    ST_PRE  = 6'h10,
    ST_REF  = 6'h20
  } drc_state_t;

  localparam int unsigned CW = $clog2(INTERVAL_CYC + 1);
  localparam int unsigned LW = $clog2(REFRESH_CYC + 1);
  localparam int unsigned PW = 8;

  drc_state_t       state_r, state_nxt;
  logic [CW-1:0]    ivl_r;
  logic [LW-1:0]    rasonly_r;
  logic [PW-1:0]    ph_r;
  logic [5:0]       refrow_r;
  logic             ref_pend_r, need_dummy_r, is_ref_r, init_r;
  logic [6:0]       init_cnt_r;
  drc_pkg::drc_req_t cur_r;
  logic [CHIPS-1:0] ras_r, dout_s1, dout_s2, dout_s3;
  logic             cas_n_r, cs_n_r, write_n_r, din_r, rdv_r, rdd_r, rdy_r;
  logic [5:0]       addr_r;

  // A dummy cycle is due from the very cycle the row-only run gets too long.
  wire long_rasonly = (rasonly_r == LW'(REFRESH_CYC));
  wire dummy_due  = need_dummy_r || long_rasonly;                  // [R6]
  // Refresh cycles use both strobes until init and after long row-only runs.
  wire both_ref   = !init_r || dummy_due;                          // [R13] [R6]
  wire ivl_done   = (ivl_r == CW'(INTERVAL_CYC - 1));              // [R16]
  wire ph_done    = (ph_r == '0);
  // A due dummy cycle goes out at once, and no access may run before it.
  wire start_ref  = (state_r == ST_IDLE) && (ref_pend_r || dummy_due);
  wire start_acc  = (state_r == ST_IDLE) && !ref_pend_r && !dummy_due &&
                    req_valid && init_r;                           // [R6]
  wire [CHIPS-1:0] chip_sel = (CHIPS)'(1) << req.chip;             // [R8]
  wire [$clog2(CHIPS)-1:0] rd_idx = cur_r.chip[$clog2(CHIPS)-1:0];
  wire rd_bit     = dout_s3[rd_idx];
  // Only the addressed chip must have settled; unselected outputs float.
  wire rd_ok      = (dout_s2[rd_idx] == dout_s3[rd_idx]);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_ref) state_nxt = ST_REF;
        else if (start_acc) state_nxt = ST_ROW;
      end
      ST_ROW:  if (ph_done) state_nxt = ST_COL;
      ST_COL:  if (ph_done) state_nxt = ST_ACT;
      ST_ACT:  if (ph_done) state_nxt = ST_PRE;
      ST_REF:  if (ph_done) state_nxt = is_ref_r && both_ref ? ST_COL : ST_ACT;
      ST_PRE:  if (ph_done) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      ph_r    <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        case (state_nxt)
          ST_ROW, ST_REF: ph_r <= PW'(drc_pkg::T_RCD_CYC - 1);
          ST_COL:         ph_r <= PW'(drc_pkg::T_ACT_CYC - 1);
          ST_ACT:         ph_r <= PW'(0);
          ST_PRE:         ph_r <= PW'(drc_pkg::T_PRE_CYC - 1);
          default:        ph_r <= '0;
        endcase
      end else if (!ph_done) begin
        ph_r <= ph_r - PW'(1);
      end
    end
  end

  // Interval timer and refresh row counter.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ivl_r      <= '0;
      ref_pend_r <= 1'b0;
      refrow_r   <= drc_pkg::ROW_RESET;
    end else begin
      ivl_r <= ivl_done ? '0 : ivl_r + CW'(1);                       // [R1] [R16]
      if (ivl_done) ref_pend_r <= 1'b1;                             // set wins
      else if (start_ref) ref_pend_r <= 1'b0;
      if (state_r == ST_PRE && ph_done && is_ref_r)
        refrow_r <= refrow_r + 6'h01;                               // [R16]
    end
  end

  // Power-up pass and row-only run tracking.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      init_r       <= 1'b0;
      init_cnt_r   <= '0;
      rasonly_r    <= '0;
      need_dummy_r <= 1'b0;
      is_ref_r     <= 1'b0;
      cur_r        <= '0;
    end else begin
      if (start_ref) is_ref_r <= 1'b1;
      else if (start_acc) begin
        is_ref_r <= 1'b0;
        cur_r    <= req;
      end
      if (state_r == ST_PRE && ph_done && is_ref_r && !init_r) begin
        init_cnt_r <= init_cnt_r + 7'h01;
        if (init_cnt_r == 7'(drc_pkg::ROW_COUNT - 1)) init_r <= 1'b1; // [R13]
      end
      // Column strobe cycles rearm the output buffers.
      if (state_r == ST_COL) begin
        rasonly_r    <= '0;
        need_dummy_r <= 1'b0;                                       // [R7]
      end else if (!long_rasonly) begin
        rasonly_r <= rasonly_r + LW'(1);
      end else begin
        need_dummy_r <= 1'b1;                                       // [R5] [R6]
      end
    end
  end

  // Pin drivers.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ras_r     <= '0;
      cas_n_r   <= 1'b1;
      cs_n_r    <= 1'b1;
      write_n_r <= 1'b1;
      addr_r    <= '0;
      din_r     <= 1'b0;
      rdy_r     <= 1'b0;
      rdv_r     <= 1'b0;
      rdd_r     <= 1'b0;
      dout_s1   <= '0;
      dout_s2   <= '0;
      dout_s3   <= '0;
    end else begin
      dout_s1 <= dout;
      dout_s2 <= dout_s1;
      dout_s3 <= dout_s2;
      rdy_r   <= start_acc;
      if (start_ref) begin
        addr_r    <= refrow_r;                                      // [R15]
        cs_n_r    <= 1'b1;                                          // [R4]
        write_n_r <= 1'b1;                                          // [R3]
      end else if (start_acc) begin
        addr_r    <= req.row;                                       // [R15]
        cs_n_r    <= 1'b0;                                          // [R11]
        write_n_r <= ~req.write;
        din_r     <= req.wdata;
      end
      case (state_nxt)
        ST_ROW:  ras_r <= chip_sel;                                 // [R8]
        ST_REF:  ras_r <= {CHIPS{1'b1}};                            // [R2]
        ST_PRE:  ras_r <= '0;
        ST_IDLE: ras_r <= '0;
        default: ras_r <= ras_r;
      endcase
      if (state_r == ST_ROW && ph_done) addr_r <= cur_r.col;
      // Row-only refresh keeps the column strobe high.
      cas_n_r <= !(state_nxt == ST_COL || state_nxt == ST_ACT) ||
                 (state_nxt == ST_ACT && is_ref_r && !both_ref);    // [R12] [R9] [R14]
      rdv_r   <= (state_r == ST_ACT) && !is_ref_r && !cur_r.write && rd_ok;
      if (state_r == ST_ACT && !is_ref_r) rdd_r <= rd_bit;
    end
  end

  assign ras       = ras_r;
  assign cas_n     = cas_n_r;                                       // [R10]
  assign cs_n      = cs_n_r;
  assign write_n   = write_n_r;
  assign addr      = addr_r;
  assign din       = din_r;
  assign req_ready = rdy_r;
  assign rd_valid  = rdv_r;
  assign rd_data   = rdd_r;
  assign init_done = init_r;
endmodule : drc_ctrl

// ---- test/drc_ctrl_assertions.sv ----
/* Checker for the drc_ctrl pins.
   Assumes the bind below reaches every drc_ctrl instance. */
`timescale 1ns/1ps
module drc_ctrl_checker #(
  parameter int unsigned CHIPS        = 4,
  parameter int unsigned INTERVAL_CYC = 40,
  parameter int unsigned REFRESH_CYC  = 400
) (
  // Watched ports
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             req_valid,
  input wire drc_pkg::drc_req_t req,
  input wire logic             req_ready,
  input wire logic             init_done,
  input wire logic [CHIPS-1:0] ras,
  input wire logic             cas_n,
  input wire logic             cs_n,
  input wire logic [5:0]       addr
);
  int unsigned gap_r;
  int unsigned both_r;
  int unsigned quiet_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_r   <= 0;
      both_r  <= 0;
      quiet_r <= 0;
    end else begin
      gap_r   <= $rose(&ras) ? 0 : gap_r + 1;
      both_r  <= both_r + int'($fell(cas_n) && (&ras));
      quiet_r <= cas_n ? quiet_r + 1 : 0;
    end
  end
  a_refresh_deselect: assert property (&ras |-> cs_n) else $error("select on refresh");
  a_access_onehot: assert property ((|ras && !(&ras)) |-> $onehot(ras))
    else $error("row strobe not decoded");
  a_cas_with_ras: assert property (!cas_n |-> |ras) else $error("lone column strobe");
  a_row_addr_hold: assert property ($rose(|ras) && !(&ras) |-> cas_n && addr == $past(req.row))
    else $error("row address not on pins");
  a_cas_after_row: assert property ($fell(cas_n) |-> $past(|ras))
    else $error("column strobe too early");
  a_dummy_first: assert property (req_ready |-> quiet_r <= REFRESH_CYC + 1)
    else $error("access without dummy cycle");
  a_ready_pulse: assert property (req_ready |=> !req_ready) else $error("ready too long");
  a_ready_cause: assert property (req_ready |-> $past(req_valid) && init_done)
    else $error("ready without request");
  a_refresh_gap: assert property (gap_r <= INTERVAL_CYC + 20) else $error("refresh late");
  a_init_both: assert property ($rose(init_done) |-> both_r >= 64)
    else $error("init too short");
endmodule : drc_ctrl_checker
bind drc_ctrl drc_ctrl_checker #(.CHIPS(CHIPS), .INTERVAL_CYC(INTERVAL_CYC),
  .REFRESH_CYC(REFRESH_CYC)) chk_u (
  .clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .init_done(init_done), .ras(ras), .cas_n(cas_n), .cs_n(cs_n), .addr(addr));

// ---- test/drc_dram_model.sv ----
/* Behavioural array of 4096 x 1 dynamic RAM chips.
   Assumes strobes that change on the clock. */
`timescale 1ns/1ps
module drc_dram_model #(parameter int CHIPS = 4, parameter int LOSE_CYC = 400) (
  // Strobes and data
  input  wire logic             clk,
  input  wire logic [CHIPS-1:0] ras,
  input  wire logic             cas_n,
  input  wire logic             cs_n,
  input  wire logic             write_n,
  input  wire logic [5:0]       addr,
  input  wire logic             din,
  output logic [CHIPS-1:0]      dout
);
  logic             mem [CHIPS][4096];
  logic [5:0]       row [CHIPS];
  logic [CHIPS-1:0] on = '0, q, pr = '0;
  logic             pc = 1'b1, flip = 1'b0;
  int               quiet = 0;
  // An open output shows a toggling level, never the last data.
  assign dout = (on & q) | (~on & {CHIPS{flip}});
  always @(posedge clk) begin
    flip <= ~flip;
    pr <= ras;
    pc <= cas_n;
    // A long run without a column strobe lets every output buffer float.
    quiet <= (!cas_n && pc) ? 0 : quiet + 1;
    if (quiet >= LOSE_CYC) on <= '0;
    for (int i = 0; i < CHIPS; i++) begin
      if (ras[i] && !pr[i]) row[i] <= addr;
      if (!cas_n && pc) begin
        on[i] <= ras[i] && !cs_n;
        q[i] <= !write_n ? 1'b1 : mem[i][{row[i], addr}];
        if (ras[i] && !cs_n && !write_n) mem[i][{row[i], addr}] <= din;
      end
    end
  end
endmodule : drc_dram_model

// ---- test/drc_ctrl_test.sv ----
/* Self-checking bench for drc_ctrl driving a dynamic RAM array model.
   Assumes shortened refresh counts set through parameters. */
`timescale 1ns/1ps
module drc_ctrl_test;
  localparam int CHIPS = 4;
  logic clk, reset, req_valid, req_ready, rd_valid, rd_data, init_done;
  logic cas_n, cs_n, write_n, din, dummy_seen, pfull;
  logic [CHIPS-1:0] ras, dout;
  logic [5:0] addr, nrow;
  drc_pkg::drc_req_t req;
  int n_errors, cmp_count;
  drc_ctrl #(.CHIPS(CHIPS), .INTERVAL_CYC(40), .REFRESH_CYC(400)) dut_u (.clk(clk),
    .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done), .ras(ras),
    .cas_n(cas_n), .cs_n(cs_n), .write_n(write_n), .addr(addr), .din(din), .dout(dout));
  drc_dram_model #(.CHIPS(CHIPS)) mem_u (.clk(clk), .ras(ras), .cas_n(cas_n),
    .cs_n(cs_n), .write_n(write_n), .addr(addr), .din(din), .dout(dout));
  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic wait_for(input string nm, ref logic sig, input int lim);
    for (int i = 0; i < lim && sig !== 1'b1; i++) @(posedge clk);
    check(nm, {7'h0, sig}, 8'h01);
    if (sig !== 1'b1) complete_run();
  endtask : wait_for
  task automatic access(input logic wr, input int ch, input logic [5:0] row, col,
                        input logic wd);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{write: wr, chip: 6'(ch), row: row, col: col, wdata: wd};
    @(posedge clk);
    wait_for("ready", req_ready, 300);
    req_valid <= 1'b0;
    check("row strobe", {4'h0, ras}, 8'h01 << ch);
    check("row address", {2'h0, addr}, {2'h0, row});
    if (!wr) begin
      wait_for("read valid", rd_valid, 40);
      check("read data", {7'h0, rd_data}, {7'h0, wd});
    end
  endtask : access
  task automatic power_up;
    int early;
    early = 0;
    req <= '{write: 1'b1, chip: 6'h00, row: 6'h00, col: 6'h00, wdata: 1'b1};
    req_valid <= 1'b1;
    for (int i = 0; i < 4000 && init_done !== 1'b1; i++) begin
      @(posedge clk);
      early += int'(req_ready === 1'b1);
    end
    check("ready before init", early[7:0], 8'h00);
    wait_for("init done", init_done, 1);
    wait_for("ready", req_ready, 300);
    req_valid <= 1'b0;
  endtask : power_up
  task automatic rw_all;
    for (int c = 0; c < CHIPS; c++) access(1'b1, c, {6{c[0]}}, {6{~c[0]}}, ~c[0]);
    for (int c = 0; c < CHIPS; c++) access(1'b0, c, {6{c[0]}}, {6{~c[0]}}, ~c[0]);
    access(1'b0, 0, 6'h00, 6'h00, 1'b1);
  endtask : rw_all
  task automatic long_idle;
    dummy_seen <= 1'b0;
    repeat (520) @(posedge clk);
    access(1'b0, 1, 6'h3f, 6'h00, 1'b0);
    check("dummy cycle", {7'h0, dummy_seen}, 8'h01);
  endtask : long_idle
  // Refresh rows must run in order, with every chip deselected.
  always @(posedge clk) begin
    pfull <= &ras;
    if (reset) begin
      nrow <= drc_pkg::ROW_RESET;
    end else if (&ras && !pfull) begin
      check("refresh row", {2'h0, addr}, {2'h0, nrow});
      check("refresh select", {7'h0, cs_n}, 8'h01);
      nrow <= nrow + 6'h01;
    end
    if (&ras && !cas_n && init_done) dummy_seen <= 1'b1;
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    dummy_seen = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    power_up();
    rw_all();
    long_idle();
    complete_run();
  end
endmodule : drc_ctrl_test
